//--- ais_pkg.sv
/*
 * Package for the analog input scaling and status block: register
 * offsets, feature bit positions, reset values, output formats and
 * timing constants.
 * Assumes a 20 MHz system clock and a 32-bit APB register bus.
 */
package ais_pkg;

   // Register byte offsets
   localparam logic [7:0] AIS_FEATURE_OFS   = 8'h00;
   localparam logic [7:0] AIS_FOFS_OFS      = 8'h04;
   localparam logic [7:0] AIS_FGAIN_OFS     = 8'h08;
   localparam logic [7:0] AIS_MOFS_OFS      = 8'h0c;
   localparam logic [7:0] AIS_MGAIN_OFS     = 8'h10;
   localparam logic [7:0] AIS_UOFS_OFS      = 8'h14;
   localparam logic [7:0] AIS_UGAIN_OFS     = 8'h18;
   localparam logic [7:0] AIS_IRQ_STAT_OFS  = 8'h1c;
   localparam logic [7:0] AIS_IRQ_MASK_OFS  = 8'h20;
   localparam logic [7:0] AIS_STATUS_OFS    = 8'h24;
   localparam logic [7:0] AIS_PD_TOUCH_OFS  = 8'h28;

   // Feature register fields
   localparam int AIS_FEAT_USER_BIT  = 0;
   localparam int AIS_FEAT_MAKER_BIT = 1;
   localparam int AIS_FEAT_FMT_LSB   = 2;
   localparam logic [15:0] AIS_FEATURE_RST = 16'h0002;

   // Coefficient reset values, factory and user gains are Q1.14 (16384 = 1.0)
   localparam int AIS_GAIN_FRAC = 14;
   localparam logic signed [15:0] AIS_GAIN_ONE  = 16'sh4000;
   localparam logic signed [15:0] AIS_OFS_ZERO  = 16'sh0000;
   // Default maker gain maps 12-bit full scale onto 0x7fff: 32767/4095
   // in Q4.11, so 4095 steps land on 32767 after the shift
   localparam logic signed [15:0] AIS_MGAIN_RST = 16'sh4004;
   localparam int AIS_MGAIN_FRAC = 11;

   // Saturation bounds of the process data word
   localparam logic signed [47:0] AIS_SAT_MAX = 48'sh0000_0000_7fff;
   localparam logic signed [47:0] AIS_SAT_MIN = 48'shffff_ffff_8000;

   // Overcurrent threshold in converter steps (20.8 mA of 20 mA span)
   localparam real AIS_OVERCUR_UA = 20800.0;
   localparam real AIS_SPAN_UA    = 20000.0;
   localparam logic [11:0] AIS_ADC_FULL = 12'hfff;

   // Watchdog: 100 ms at 20 MHz
   localparam int AIS_WDOG_MS    = 100;
   localparam int AIS_CLK_HZ     = 20_000_000;
   localparam int AIS_WDOG_CYC   = AIS_WDOG_MS * (AIS_CLK_HZ / 1000);

   // Output representations
   typedef enum logic [1:0] {
      AIS_FMT_TWOS,
      AIS_FMT_SIGNMAG,
      AIS_FMT_ALTPLC
   } ais_fmt_t;

   // Interrupt status bit positions
   localparam int AIS_IRQ_WDOG = 0;
   localparam int AIS_IRQ_OVER = 1;
   localparam int AIS_IRQ_W    = 2;

   // One converter sample in
   typedef struct packed {
      logic [2:0]  chan;
      logic [11:0] value;
   } ais_sample_t;

   // One process data word out
   typedef struct packed {
      logic [2:0]  chan;
      logic [15:0] word;
   } ais_pdword_t;

endpackage : ais_pkg

//--- ais_scale.sv
/*
 * Analog input scaling and status: compensates, scales and formats
 * converter samples into process data words and drives the per-channel
 * run and error indicators, with an APB register file and interrupt.
 * Assumes samples arrive as single-cycle strobes, and that the coupler
 * side pulses pd_exchange on each process data exchange.
 */
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps

module ais_scale
   import ais_pkg::*;
#(
   parameter int N_CHAN   = 8,
   parameter int WDOG_CYC = AIS_WDOG_CYC
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              sample_valid,
   input  wire ais_sample_t       sample_in,
   input  wire logic              pd_exchange,
   output logic                   pd_valid,
   output ais_pdword_t            pd_out,
   output logic [N_CHAN-1:0]      run_led,
   output logic [N_CHAN-1:0]      err_led,
   output logic                   irq
);

   // Threshold in steps; clamped so it never wraps below full scale
   localparam int OVER_STEPS =
      int'(AIS_OVERCUR_UA / AIS_SPAN_UA * real'(AIS_ADC_FULL));
   localparam logic [11:0] OVER_LIM =
      (OVER_STEPS > int'(AIS_ADC_FULL)) ? AIS_ADC_FULL : 12'(OVER_STEPS);
   localparam int WDW = $clog2(WDOG_CYC + 1);

   logic [15:0]        feature_select_register;
   logic signed [15:0] factory_offset_coefficient;
   logic signed [15:0] factory_gain_coefficient;
   logic signed [15:0] maker_scale_offset;
   logic signed [15:0] maker_scale_gain;
   logic signed [15:0] user_scale_offset;
   logic signed [15:0] user_scale_gain;
   logic [AIS_IRQ_W-1:0] irq_stat_reg;
   logic [AIS_IRQ_W-1:0] irq_mask_reg;
   logic [AIS_IRQ_W-1:0] irq_event;
   logic [WDW-1:0]     wdog_cnt_reg;
   logic               wdog_trip_reg;
   logic               wdog_trip_d_reg;
   logic               wr_en;
   logic               rd_en;
   logic               pd_touch;
   logic               over_now;
   logic [N_CHAN-1:0]  over_reg;
   logic signed [47:0] comp_val;
   logic signed [47:0] maker_val;
   logic signed [47:0] user_in;
   logic signed [47:0] user_val;
   logic signed [47:0] final_val;
   logic signed [15:0] sat_val;
   logic [15:0]        fmt_word;
   ais_fmt_t           fmt_sel;

   // APB access strobes; zero wait states
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign pd_touch = wr_en && (paddr == AIS_PD_TOUCH_OFS);

   // Configuration registers written by software
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         feature_select_register    <= AIS_FEATURE_RST;
         factory_offset_coefficient <= AIS_OFS_ZERO;
         factory_gain_coefficient   <= AIS_GAIN_ONE;
         maker_scale_offset         <= AIS_OFS_ZERO;
         maker_scale_gain           <= AIS_MGAIN_RST;
         user_scale_offset          <= AIS_OFS_ZERO;
         user_scale_gain            <= AIS_GAIN_ONE;
         irq_mask_reg               <= '0;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            AIS_FEATURE_OFS:  feature_select_register    <= pwdata[15:0];
            AIS_FOFS_OFS:     factory_offset_coefficient <= pwdata[15:0];
            AIS_FGAIN_OFS:    factory_gain_coefficient   <= pwdata[15:0];
            AIS_MOFS_OFS:     maker_scale_offset         <= pwdata[15:0];
            AIS_MGAIN_OFS:    maker_scale_gain           <= pwdata[15:0];
            AIS_UOFS_OFS:     user_scale_offset          <= pwdata[15:0];
            AIS_UGAIN_OFS:    user_scale_gain            <= pwdata[15:0];
            AIS_IRQ_MASK_OFS: irq_mask_reg <= pwdata[AIS_IRQ_W-1:0];
            default:          ;
         endcase
      end
   end

   // Read mux; unmapped addresses answer with an error and zero data
   always_comb
   begin
      prdata  = '0;
      pslverr = 1'b0;
      unique case (paddr)
         AIS_FEATURE_OFS:  prdata[15:0] = feature_select_register;
         AIS_FOFS_OFS:     prdata[15:0] = factory_offset_coefficient;
         AIS_FGAIN_OFS:    prdata[15:0] = factory_gain_coefficient;
         AIS_MOFS_OFS:     prdata[15:0] = maker_scale_offset;
         AIS_MGAIN_OFS:    prdata[15:0] = maker_scale_gain;
         AIS_UOFS_OFS:     prdata[15:0] = user_scale_offset;
         AIS_UGAIN_OFS:    prdata[15:0] = user_scale_gain;
         AIS_IRQ_STAT_OFS: prdata[AIS_IRQ_W-1:0] = irq_stat_reg;
         AIS_IRQ_MASK_OFS: prdata[AIS_IRQ_W-1:0] = irq_mask_reg;
         AIS_STATUS_OFS:   prdata[N_CHAN:0] = {over_reg, wdog_trip_reg};
         AIS_PD_TOUCH_OFS: prdata = '0;
         default:          pslverr = psel & penable;
      endcase
   end

   // Watchdog: restarted by any process data exchange
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wdog_cnt_reg    <= '0;
         wdog_trip_reg   <= 1'b0;
         wdog_trip_d_reg <= 1'b0;
      end
      else
      begin
         wdog_trip_d_reg <= wdog_trip_reg;
         if (pd_exchange || pd_touch)
         begin
            wdog_cnt_reg  <= '0;
            wdog_trip_reg <= 1'b0;
         end
         else if (wdog_cnt_reg >= WDW'(WDOG_CYC))
            wdog_trip_reg <= 1'b1;
         else
            wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      end
   end

   // Run indicators go dark together on watchdog overflow
   assign run_led = wdog_trip_reg ? '0 : '1;

   // Overcurrent per channel, updated on each sample of that channel
   assign over_now = sample_in.value > OVER_LIM;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         over_reg <= '0;
      else if (sample_valid)
         over_reg[sample_in.chan] <= over_now;
   end
   assign err_led = over_reg;

   // Compensation and scaling chain; 48 bits keeps products exact
   always_comb
   begin
      comp_val  = ((48'(signed'(factory_offset_coefficient)) +
                   48'(signed'({1'b0, sample_in.value}))) *
                   48'(factory_gain_coefficient)) >>> AIS_GAIN_FRAC;
      maker_val = 48'(maker_scale_offset) +
                  ((48'(maker_scale_gain) * comp_val) >>> AIS_MGAIN_FRAC);
      user_in   = feature_select_register[AIS_FEAT_MAKER_BIT] ?
                  maker_val : comp_val;
      user_val  = 48'(user_scale_offset) +
                  ((48'(user_scale_gain) * user_in) >>> AIS_GAIN_FRAC);
      final_val = feature_select_register[AIS_FEAT_USER_BIT] ?
                  user_val : user_in;
   end

   // Clamp before formatting so large gains cannot wrap
   assign sat_val = (final_val > AIS_SAT_MAX) ? AIS_SAT_MAX[15:0] :
                    (final_val < AIS_SAT_MIN) ? AIS_SAT_MIN[15:0] :
                    final_val[15:0];

   // Output representation; unused codes fall back to two's complement
   assign fmt_sel = ais_fmt_t'(feature_select_register[AIS_FEAT_FMT_LSB +: 2]);
   always_comb
   begin
      case (fmt_sel)
         AIS_FMT_SIGNMAG:
            fmt_word = sat_val[15] ?
                       {1'b1, 15'(-sat_val)} : sat_val;
         AIS_FMT_ALTPLC:
            fmt_word = {sat_val[15], sat_val[15:4], 3'h0};
         default:
            fmt_word = sat_val;
      endcase
   end

   // Registered process data word, one cycle after the sample strobe
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pd_valid <= 1'b0;
         pd_out   <= '0;
      end
      else
      begin
         pd_valid <= sample_valid;
         if (sample_valid)
         begin
            pd_out.chan <= sample_in.chan;
            pd_out.word <= fmt_word;
         end
      end
   end

   // Sticky interrupt status; a new event beats a same-cycle clear
   assign irq_event[AIS_IRQ_WDOG] = wdog_trip_reg & ~wdog_trip_d_reg;
   assign irq_event[AIS_IRQ_OVER] = sample_valid & over_now;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         irq_stat_reg <= '0;
      else if (wr_en && paddr == AIS_IRQ_STAT_OFS)
         irq_stat_reg <= (irq_stat_reg & ~pwdata[AIS_IRQ_W-1:0]) | irq_event;
      else
         irq_stat_reg <= irq_stat_reg | irq_event;
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule : ais_scale

//--- ais_scale_assertions.sv
/* Port-level timing checks for ais_scale.
   Bound from the testbench top; sees only the top module ports. */
`timescale 1ns/1ps
module ais_scale_assertions
   import ais_pkg::*;
#(parameter int N_CHAN = 8, parameter int WDOG_CYC = 50)
(
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              sample_valid,
   input wire ais_sample_t       sample_in,
   input wire logic              pd_exchange,
   input wire logic              pd_valid,
   input wire ais_pdword_t       pd_out,
   input wire logic [N_CHAN-1:0] run_led,
   input wire logic [N_CHAN-1:0] err_led
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [15:0] idle_reg;
   // Cycles since last exchange; saturates so a long stall never wraps
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         idle_reg <= '0;
      else if (pd_exchange || (psel && penable && pwrite &&
               paddr == AIS_PD_TOUCH_OFS))
         idle_reg <= '0;
      else if (idle_reg != 16'hffff)
         idle_reg <= idle_reg + 16'h1;
   sequence s_sample;
      sample_valid ##1 pd_valid;
   endsequence
   sequence s_relight;
      pd_exchange ##1 (&run_led);
   endsequence
   a_pd_follows: assert property (sample_valid |-> s_sample)
      else $error("no word after sample");
   a_pd_cause: assert property (pd_valid |-> $past(sample_valid))
      else $error("word without sample");
   a_pd_chan: assert property (sample_valid |=>
      pd_out.chan == $past(sample_in.chan)) else $error("channel lost");
   a_pd_hold: assert property (!pd_valid |-> $stable(pd_out))
      else $error("word changed between samples");
   a_err_dark: assert property (err_led == '0)
      else $error("error indicator lit in range");
   a_run_lit: assert property (idle_reg < WDOG_CYC - 2 |-> &run_led)
      else $error("run indicator dark too early");
   a_run_trip: assert property (idle_reg > WDOG_CYC + 3 |->
      run_led == '0) else $error("run indicator not out");
   a_run_relit: assert property (pd_exchange |-> s_relight)
      else $error("run indicator not relit");
   a_apb_err: assert property (psel && penable &&
      paddr > AIS_PD_TOUCH_OFS |-> pready && pslverr)
      else $error("unmapped access not refused");
endmodule : ais_scale_assertions

//--- ais_coupler_model.sv
/* Bus coupler model: one-cycle exchange pulse every period+1 cycles.
   Assumes it shares the block clock; stopping run starves the block. */
`timescale 1ns/1ps
module ais_coupler_model
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [7:0] period,
   output logic            pd_exchange
);
   logic [7:0] tick_reg;
   // Exchange cadence; a period longer than WDOG_CYC still trips the watchdog
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         tick_reg    <= 8'h0;
         pd_exchange <= 1'b0;
      end
      else
      begin
         pd_exchange <= run && tick_reg == 8'h0;
         tick_reg    <= (tick_reg >= period) ? 8'h0 : tick_reg + 8'h1;
      end
endmodule : ais_coupler_model

//--- ais_scale_tb.sv
/* Self-checking bench for ais_scale: APB master, sample driver and
   coupler model. Assumes checker and model compile before it. */
`timescale 1ns/1ps
module ais_scale_tb;
   import ais_pkg::*;
   localparam int WD = 50;
   logic               sys_clk, rst, psel, penable, pwrite, perr;
   logic               pready, pslverr, pd_valid, irq, cpl_run;
   logic               sample_valid, pd_exchange;
   logic [7:0]         paddr, cpl_period, run_led, err_led;
   logic [31:0]        pwdata, prdata, rd;
   logic [1:0]         en;
   logic [11:0]        x;
   logic signed [15:0] co [6];
   ais_sample_t        sample_in;
   ais_pdword_t        pd_out;
   int                 bad_count, compares, cyc, seed;
   ais_scale #(.WDOG_CYC(WD)) u_dut (.sys_clk, .rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_valid,
      .sample_in, .pd_exchange, .pd_valid, .pd_out, .run_led, .err_led,
      .irq);
   ais_coupler_model u_cpl (.sys_clk, .rst, .run(cpl_run),
      .period(cpl_period), .pd_exchange);
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      if (seen !== exp)
         bad_count++;
   endtask : check
   // One APB transfer; waits on pready, takes data at that edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One sample; the word is due one cycle after the strobe
   task automatic samp(input logic [11:0] v);
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      sample_in    <= '{chan: 3'($random(seed)), value: v};
      @(posedge sys_clk);
      sample_valid <= 1'b0;
      #1;
      check(pd_valid, 1'b1);
      check(err_led, 8'h00);
   endtask : samp
   // Reference chain with saturation to the word range
   function automatic logic [15:0] exp_word(input logic [11:0] v);
      logic signed [47:0] y;
      y = (48'(co[0]) + 48'(signed'({1'b0, v}))) * co[1] >>> 14;
      if (en[1]) y = 48'(co[2]) + (48'(co[3]) * y >>> AIS_MGAIN_FRAC);
      if (en[0]) y = 48'(co[4]) + (48'(co[5]) * y >>> AIS_GAIN_FRAC);
      if (y > AIS_SAT_MAX) y = AIS_SAT_MAX;
      if (y < AIS_SAT_MIN) y = AIS_SAT_MIN;
      return y[15:0];
   endfunction : exp_word
   task automatic stop_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   // Hang guard, well above the expected run length
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end
   initial
   begin
      {psel, penable, pwrite, sample_valid, cpl_run, rst} = 6'h1;
      {paddr, pwdata, sample_in, cpl_period, seed} = {55'h0, 8'ha, 32'h2363};
      repeat (12) @(posedge sys_clk);
      rst     <= 1'b0;
      cpl_run <= 1'b1;
      apb(0, AIS_FEATURE_OFS, 0);
      check(rd, 32'(AIS_FEATURE_RST));
      apb(0, 8'h3c, 0);
      check(perr, 1'b1);
      check(rd, 32'h0);
      samp(12'h000);
      check(pd_out.word, 16'h0000);
      samp(12'hfff);
      check(pd_out.word, 16'h7fff);
      apb(1, AIS_FOFS_OFS, 32'hffff);
      for (int f = 0; f < 3; f++)
      begin
         apb(1, AIS_FEATURE_OFS, 32'(f << AIS_FEAT_FMT_LSB));
         samp(12'h000);
         check({pd_out.word[15], pd_out.word[2:0]},
               f == 0 ? 16'hf : f == 1 ? 16'h9 : 16'h8);
      end
      $display("test formats done");
      repeat (24)
      begin
         for (int i = 0; i < 6; i++)
         begin
            co[i] = i[0] ? {1'b0, 15'($random(seed))} : 16'($random(seed));
            apb(1, 8'(4 * i + 4), {16'h0, co[i]});
         end
         en = 2'($random(seed));
         apb(1, AIS_FEATURE_OFS, {30'h0, en});
         cpl_period <= 8'($unsigned($random(seed)) % 40);
         repeat (4)
         begin
            x = 12'($random(seed));
            samp(x);
            check(pd_out.word, exp_word(x));
         end
      end
      $display("test scaling done");
      cpl_run <= 1'b0;
      repeat (WD + 10) @(posedge sys_clk);
      check({run_led, irq}, 9'h0);
      apb(1, AIS_IRQ_MASK_OFS, 32'h1);
      @(posedge sys_clk);
      check(irq, 1'b1);
      apb(1, AIS_IRQ_STAT_OFS, 32'h1);
      apb(0, AIS_IRQ_STAT_OFS, 0);
      check({rd[0], irq}, 2'b00);
      cpl_run <= 1'b1;
      // Next exchange may be a whole coupler period away
      repeat (int'(cpl_period) + 4) @(posedge sys_clk);
      check(run_led, 8'hff);
      $display("test watchdog done");
      stop_test();
   end
endmodule : ais_scale_tb

bind ais_scale ais_scale_assertions #(.N_CHAN(N_CHAN), .WDOG_CYC(WDOG_CYC))
   u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pready,
      .pslverr, .sample_valid, .sample_in, .pd_exchange, .pd_valid,
      .pd_out, .run_led, .err_led);
